// >>> disk_write_timing_hard_sector_format_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwf_regs.svh"

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end

module disk_write_timing_hard_sector_format_tb import dwf_pkg::*; ;
  localparam int ENC = 4;
  localparam int BPS = 64;
  localparam int SEC = 4;
  localparam int REF = `DWF_REF_DIV;

  logic sys_clk = 1'b0;
  logic rst_n   = 1'b0;
  logic write_gate, am_enable, write_clk, write_data;
  logic ref_clk, index, sector, drive_en, splice, rec_strobe, rec_data, am_req;
  logic wclk_q, gate_q, en_q, spl_q, sec_q, idx_q, en_seen, sec_seen, idx_seen;
  logic ref_q, ref_seen;
  int   rcnt;
  logic [3:0] hist;
  logic sent[$];
  int   gcnt, splen, scnt, icnt, nstb;
  int   failures   = 0;
  int   n_compared = 0;

  always #20 sys_clk = ~sys_clk;

  dwf_write_path #(.TURN_ON(`DWF_TURN_ON_DEF), .ENC_DELAY(ENC), .BITS_PER_SECTOR(BPS),
    .SECTORS(SEC), .PULSE_BITS(`DWF_PULSE_BITS)) dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .write_gate_i(write_gate),
    .am_enable_i(am_enable), .write_clk_i(write_clk), .write_data_i(write_data),
    .ref_clk_o(ref_clk), .index_o(index), .sector_o(sector), .drive_en_o(drive_en),
    .splice_o(splice), .rec_strobe_o(rec_strobe), .rec_data_o(rec_data), .am_req_o(am_req));

  dwf_ctrl_model ctl (
    .sys_clk_i(sys_clk), .write_gate_o(write_gate), .am_enable_o(am_enable),
    .write_clk_o(write_clk), .write_data_o(write_data));

  task automatic conclude();
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Reference model: every bit the controller sends, indexed by write clock edge.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      {gcnt, splen, scnt, icnt} = '0;
      {en_seen, sec_seen, idx_seen, wclk_q, gate_q, en_q, spl_q, sec_q, idx_q} = '0;
      hist = 4'h0;
      {ref_q, ref_seen} = 2'b00;
      rcnt = 0;
    end else begin
      if (write_clk && !wclk_q) sent.push_back(write_data);
      if (rec_strobe) nstb++;
      if (rec_strobe && sent.size() > ENC) `CHK(rec_data, sent[sent.size() - 1 - ENC])
      gcnt++;
      if (write_gate && !gate_q) gcnt = 0;
      if (drive_en && !en_q) `CHK(gcnt >= 3 * REF && gcnt <= 7 * REF + 4, 1'b1)
      if (drive_en) en_seen = 1'b1;
      if (drive_en) `CHK(splice, 1'b0)
      if (spl_q && !splice) `CHK(splen <= 8 * REF, 1'b1)
      splen = splice ? splen + 1 : 0;
      if (hist == 4'h0 || hist == 4'hF) `CHK(am_req, hist[0])
      hist = {hist[2:0], write_gate & am_enable};
      scnt++;
      icnt++;
      rcnt++;
      if (ref_clk && !ref_q) begin
        if (ref_seen) `CHK(rcnt, REF)
        ref_seen = 1'b1;
        rcnt = 0;
      end
      ref_q = ref_clk;
      if (sector && !sec_q) begin
        if (sec_seen) `CHK(scnt, BPS * REF)
        sec_seen = 1'b1;
        scnt = 0;
      end
      if (index && !idx_q) begin
        `CHK(sector, 1'b1)
        if (idx_seen) `CHK(icnt, BPS * REF * SEC)
        idx_seen = 1'b1;
        icnt = 0;
      end
      {wclk_q, gate_q, en_q, spl_q, sec_q, idx_q} = {write_clk, write_gate, drive_en, splice,
        sector, index};
    end
  end

  // A frame holds the driver on from the end of turn-on inside its first byte to the gate drop, so strobes bound it.
  initial begin
    void'($urandom(32'h66ea_68e4));
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    nstb = 0;
    ctl.frame(8, 1'b0);
    `CHK(nstb >= 16 * 8, 1'b1)
    nstb = 0;
    ctl.frame(4, 1'b1);
    `CHK(nstb >= 12 * 8, 1'b1)
    en_seen = 1'b0;
    ctl.pulse(2);
    `CHK(en_seen, 1'b0)
    ctl.pulse(12);
    `CHK(en_seen, 1'b1)
    repeat (5000) @(negedge sys_clk);
    conclude();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    conclude();
  end
endmodule : disk_write_timing_hard_sector_format_tb

`default_nettype wire

// >>> dwf_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module dwf_ctrl_model (
  // Clock
  input  wire logic sys_clk_i,
  // Controller pins
  output logic      write_gate_o,
  output logic      am_enable_o,
  output logic      write_clk_o,
  output logic      write_data_o
);
  initial begin
    write_gate_o = 1'b0;
    am_enable_o  = 1'b0;
    write_clk_o  = 1'b0;
    write_data_o = 1'b0;
  end

  // Data moves on the falling write clock so it is steady at the rising one.
  task automatic bit_out(input logic b);
    repeat (4) @(negedge sys_clk_i);
    write_clk_o  = 1'b0;
    write_data_o = b;
    repeat (4) @(negedge sys_clk_i);
    write_clk_o = 1'b1;
  endtask : bit_out

  task automatic byte_out(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
  endtask : byte_out

  // The clock stands still between frames and the released data line keeps toggling.
  // The model drives no read gate and never switches heads, so those waits hold trivially.
  task automatic idle(input int bits);
    repeat (4) @(negedge sys_clk_i);
    write_clk_o = 1'b0;
    repeat (bits * 8) @(negedge sys_clk_i) write_data_o = ~write_data_o;
  endtask : idle

  // Data area in field order, with an xor byte standing in for the check code.
  task automatic frame(input int nbytes, input logic am);
    logic [7:0] chk;
    logic [7:0] d;
    chk = 8'h00;
    repeat (3) bit_out(1'b0);
    write_gate_o = 1'b1;
    repeat (2) byte_out(8'h00);
    byte_out(8'hA1);
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      chk = chk ^ d;
      byte_out(d);
    end
    byte_out(chk);
    chk = 8'h00;
    repeat (2) byte_out(8'h00);
    byte_out(8'h00);
    repeat (2) byte_out(8'h00);
    byte_out(8'hA1);
    am_enable_o = am;
    for (int i = 0; i < nbytes; i++) begin
      d = 8'($urandom);
      chk = chk ^ d;
      byte_out(d);
    end
    am_enable_o = 1'b0;
    byte_out(chk);
    repeat (2) byte_out(8'h00);
    byte_out(8'h00);
    repeat (2) byte_out(8'h00);
    write_gate_o = 1'b0;
    idle(1 + $urandom_range(3));
  endtask : frame

  task automatic pulse(input int bits);
    repeat (3) bit_out(1'b0);
    write_gate_o = 1'b1;
    repeat (bits) bit_out(1'b0);
    write_gate_o = 1'b0;
    idle(2);
  endtask : pulse
endmodule : dwf_ctrl_model

`default_nettype wire

// >>> dwf_delay_mem.sv
`timescale 1ns/1ps
`default_nettype none

module dwf_delay_mem #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Write side
  input  wire logic wr_en_i,
  input  wire logic wr_bit_i,
  // Read side
  output logic      rd_bit_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [DEPTH-1:0] mem;
  logic [AW-1:0]    ptr;

  // The cell at the pointer holds the bit written DEPTH writes ago.
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[ptr] <= wr_bit_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ptr <= '0;
    end else if (wr_en_i) begin
      ptr <= (ptr == AW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_bit_o <= 1'b0;
    end else if (wr_en_i) begin
      rd_bit_o <= mem[ptr];
    end
  end

endmodule : dwf_delay_mem

`default_nettype wire

// >>> dwf_pkg.sv
package dwf_pkg;

  typedef enum logic [1:0] {
    DWF_IDLE       = 2'b00,
    DWF_TURN_ON    = 2'b01,
    DWF_WRITE      = 2'b10,
    DWF_SPLICE_OFF = 2'b11
  } dwf_drv_state_t;

endpackage : dwf_pkg

// >>> dwf_regs.svh
`ifndef DWF_REGS_SVH
`define DWF_REGS_SVH

// Clock and link timing in nanoseconds.
`define DWF_SYS_CLK_NS       40
`define DWF_REF_PERIOD_NS    320
`define DWF_REF_DIV          (`DWF_REF_PERIOD_NS / `DWF_SYS_CLK_NS)

// Write driver turn-on window in reference clock periods.
`define DWF_TURN_ON_MIN      3
`define DWF_TURN_ON_MAX      7
`define DWF_TURN_ON_DEF      5

// Encoder delay limit in bit times and the width of a byte.
`define DWF_ENC_DELAY_MAX    8
`define DWF_BYTE_BITS        8

// Rotation layout defaults, in bit times and sectors.
`define DWF_BITS_PER_SECTOR  4096
`define DWF_SECTORS          32
`define DWF_PULSE_BITS       8

`endif

// >>> dwf_write_path.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwf_regs.svh"

module dwf_write_path
  import dwf_pkg::*;
#(
  parameter int TURN_ON         = `DWF_TURN_ON_DEF,
  parameter int ENC_DELAY       = `DWF_ENC_DELAY_MAX,
  parameter int BITS_PER_SECTOR = `DWF_BITS_PER_SECTOR,
  parameter int SECTORS         = `DWF_SECTORS,
  parameter int PULSE_BITS      = `DWF_PULSE_BITS
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Controller pins
  input  wire logic write_gate_i,
  input  wire logic am_enable_i,
  input  wire logic write_clk_i,
  input  wire logic write_data_i,
  // Timing pins toward the controller
  output logic      ref_clk_o,
  output logic      index_o,
  output logic      sector_o,
  // Recording side
  output logic      drive_en_o,
  output logic      splice_o,
  output logic      rec_strobe_o,
  output logic      rec_data_o,
  output logic      am_req_o
);

  localparam int REF_DIV = `DWF_REF_DIV;
  localparam int DW      = 4;
  localparam int BW      = $clog2(BITS_PER_SECTOR + 1);
  localparam int SW      = $clog2(SECTORS + 1);

  generate
    if (TURN_ON < `DWF_TURN_ON_MIN || TURN_ON > `DWF_TURN_ON_MAX) begin : g_bad_turn_on
      $error("TURN_ON outside the allowed window");
    end
    if (ENC_DELAY < 1 || ENC_DELAY > `DWF_ENC_DELAY_MAX) begin : g_bad_delay
      $error("ENC_DELAY outside the allowed range");
    end
    if (PULSE_BITS < 1 || PULSE_BITS >= BITS_PER_SECTOR || SECTORS < 1) begin : g_bad_layout
      $error("Sector layout parameters are inconsistent");
    end
  endgenerate

  function automatic logic rose_edge(input logic prev, input logic cur);
    rose_edge = cur & ~prev;
  endfunction : rose_edge

  function automatic logic fell_edge(input logic prev, input logic cur);
    fell_edge = prev & ~cur;
  endfunction : fell_edge

  // Pin synchronisers; the third stage is only an edge reference.
  logic [1:0] wg_sync;
  logic [1:0] am_sync;
  logic [1:0] wc_sync;
  logic [1:0] wd_sync;
  logic       wg_q;
  logic       wc_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wg_sync <= 2'h0;
      am_sync <= 2'h0;
      wc_sync <= 2'h0;
      wd_sync <= 2'h0;
      wg_q    <= 1'b0;
      wc_q    <= 1'b0;
    end else begin
      wg_sync <= {wg_sync[0], write_gate_i};
      am_sync <= {am_sync[0], am_enable_i};
      wc_sync <= {wc_sync[0], write_clk_i};
      wd_sync <= {wd_sync[0], write_data_i};
      wg_q    <= wg_sync[1];
      wc_q    <= wc_sync[1];
    end
  end

  logic wg_s;
  logic wg_rise;
  logic wg_fall;
  logic wc_rise;

  assign wg_s    = wg_sync[1];
  assign wg_rise = rose_edge(wg_q, wg_s);
  assign wg_fall = fell_edge(wg_q, wg_s);
  assign wc_rise = rose_edge(wc_q, wc_sync[1]);

  // Reference clock divider; one tick per bit time.
  logic [DW-1:0] div_cnt;
  logic          ref_tick;

  assign ref_tick = (div_cnt == DW'(REF_DIV - 1));

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      div_cnt   <= '0;
      ref_clk_o <= 1'b0;
    end else begin
      div_cnt   <= ref_tick ? '0 : div_cnt + 1'b1;
      ref_clk_o <= (div_cnt < DW'(REF_DIV / 2));
    end
  end

  // Index and sector pulses follow a free-running rotation count.
  logic [BW-1:0] bit_cnt;
  logic [SW-1:0] sec_cnt;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bit_cnt <= '0;
      sec_cnt <= '0;
    end else if (ref_tick) begin
      if (bit_cnt == BW'(BITS_PER_SECTOR - 1)) begin
        bit_cnt <= '0;
        sec_cnt <= (sec_cnt == SW'(SECTORS - 1)) ? '0 : sec_cnt + 1'b1;
      end else begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sector_o <= 1'b0;
      index_o  <= 1'b0;
    end else begin
      sector_o <= (bit_cnt < BW'(PULSE_BITS));
      index_o  <= (bit_cnt < BW'(PULSE_BITS)) && (sec_cnt == '0);
    end
  end

  // Write driver sequencing.
  dwf_drv_state_t state;
  dwf_drv_state_t next_state;
  logic [2:0]     on_cnt;

  always_comb begin
    next_state = state;
    unique case (state)
      DWF_IDLE: begin
        if (wg_rise) begin
          next_state = DWF_TURN_ON;
        end
      end
      DWF_TURN_ON: begin
        if (!wg_s) begin
          next_state = DWF_IDLE;
        end else if (ref_tick && on_cnt == 3'(TURN_ON - 1)) begin
          next_state = DWF_WRITE;
        end
      end
      DWF_WRITE: begin
        if (wg_fall) begin
          next_state = DWF_SPLICE_OFF;
        end
      end
      DWF_SPLICE_OFF: begin
        if (ref_tick) begin
          next_state = DWF_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= DWF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      on_cnt <= 3'h0;
    end else if (state != DWF_TURN_ON) begin
      on_cnt <= 3'h0;
    end else if (ref_tick) begin
      on_cnt <= on_cnt + 1'b1;
    end
  end

  // The splice window never exceeds the turn-on time, which stays within a byte.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      drive_en_o <= 1'b0;
      splice_o   <= 1'b0;
      am_req_o   <= 1'b0;
    end else begin
      drive_en_o <= (next_state == DWF_WRITE);
      splice_o   <= (next_state == DWF_TURN_ON) || (next_state == DWF_SPLICE_OFF);
      am_req_o   <= wg_s && am_sync[1];
    end
  end

  // Encoder delay line; data is sampled on write clock edges.
  logic mem_bit;
  logic stb_d;

  dwf_delay_mem #(
    .DEPTH    (ENC_DELAY)
  ) u_delay (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wc_rise),
    .wr_bit_i  (wd_sync[1]),
    .rd_bit_o  (mem_bit)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      stb_d        <= 1'b0;
      rec_strobe_o <= 1'b0;
      rec_data_o   <= 1'b0;
    end else begin
      stb_d        <= wc_rise;
      rec_strobe_o <= stb_d && (state == DWF_WRITE);
      rec_data_o   <= mem_bit;
    end
  end

  // Helper logic for the checks below.
  localparam int TON_MAX_CYC = TURN_ON * REF_DIV + 2;
  localparam int TON_MIN_CYC = (`DWF_TURN_ON_MIN - 1) * REF_DIV;
  localparam int BYTE_CYC    = `DWF_BYTE_BITS * REF_DIV;
  localparam int SEC_CYC     = BITS_PER_SECTOR * REF_DIV;

  logic [15:0]        wg_age;
  logic [7:0]         splice_len;
  logic [31:0]        since_sec;
  logic               sec_seen;
  logic [ENC_DELAY:0] hist;
  logic [3:0]         fill;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wg_age     <= 16'h0000;
      splice_len <= 8'h00;
      since_sec  <= 32'h0000_0000;
      sec_seen   <= 1'b0;
      hist       <= '0;
      fill       <= 4'h0;
    end else begin
      wg_age     <= wg_rise ? 16'h0001 : (wg_age == 16'hFFFF ? wg_age : wg_age + 1'b1);
      splice_len <= splice_o ? (splice_len == 8'hFF ? splice_len : splice_len + 1'b1) : 8'h00;
      since_sec  <= (sector_o && !sec_seen) ? 32'h0000_0001 : since_sec + 1'b1;
      sec_seen   <= sector_o;
      if (wc_rise) begin
        hist <= {hist[ENC_DELAY-1:0], wd_sync[1]};
        fill <= (fill > 4'(ENC_DELAY)) ? fill : fill + 1'b1;
      end
    end
  end

  sequence s_gate_rise;
    $rose(wg_s) && state == DWF_IDLE;
  endsequence

  sequence s_driver_on;
    ##[1:TON_MAX_CYC] (drive_en_o || !wg_s);
  endsequence

  AST_TURN_ON_LATE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i) s_gate_rise |-> s_driver_on)
    else $error("Write driver did not turn on in time.");

  AST_TURN_ON_EARLY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(drive_en_o) |-> wg_age >= TON_MIN_CYC)
    else $error("Write driver turned on too early.");

  AST_ENC_DELAY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rec_strobe_o && fill > 4'(ENC_DELAY)) |-> rec_data_o == $past(hist[ENC_DELAY], 1))
    else $error("Recorded bit is not the one written the set delay earlier.");

  AST_SECTOR_SPACING: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ($rose(sector_o) && since_sec > 32'h0000_0001) |-> since_sec == SEC_CYC)
    else $error("Sector pulses are not evenly spaced.");

  AST_INDEX_ON_SECTOR: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(index_o) |-> $rose(sector_o))
    else $error("Index pulse does not start with a sector pulse.");

  AST_SPLICE_MAX: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i) splice_o |-> splice_len < BYTE_CYC)
    else $error("Write splice is longer than one byte.");

  AST_SPLICE_CAUSE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(splice_o) |-> $past(wg_rise || wg_fall))
    else $error("Write splice started without a write gate edge.");

  AST_SHORT_PULSE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ($fell(wg_s) && state == DWF_TURN_ON) |-> ##1 !splice_o)
    else $error("Aborted write gate pulse left the splice open.");

endmodule : dwf_write_path

`default_nettype wire
